// ==== tb_timer1_countdown_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

module tb_timer1_countdown_unit;
  logic        ref_clk_i       = 1'b0;
  logic        rst_n_i         = 1'b0;
  logic [9:0]  avs_address_i   = 10'h000;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  ev              = 8'h00;
  logic        low_freq_oscillator             = 1'b0;
  logic        timer_b_underflow_o;
  logic        timer_b_running_o;
  logic        irq_o;
  int          err_count       = 0;
  int          checked         = 0;

  always #4 ref_clk_i = ~ref_clk_i;

  // event pulses: 0..3 tick sources, 4 start, 5 stop, 6 tx end, 7 rx nibble
  tmb_timer dut_u (
    .ref_clk_i             (ref_clk_i),
    .rst_n_i               (rst_n_i),
    .avs_address_i         (avs_address_i),
    .avs_read_i            (avs_read_i),
    .avs_write_i           (avs_write_i),
    .avs_writedata_i       (avs_writedata_i),
    .avs_readdata_o        (avs_readdata_o),
    .avs_waitrequest_o     (avs_waitrequest_o),
    .tick_13m56_i          (ev[0]),
    .tick_212k_i           (ev[1]),
    .timer_a_underflow_i   (ev[2]),
    .timer_c_underflow_i   (ev[3]),
    .start_now_i           (ev[4]),
    .stop_now_i            (ev[5]),
    .tx_done_i             (ev[6]),
    .rx_first_nibble_i     (ev[7]),
    .low_freq_oscillator_i (low_freq_oscillator),
    .timer_b_underflow_o   (timer_b_underflow_o),
    .timer_b_running_o     (timer_b_running_o),
    .irq_o                 (irq_o)
  );

  //////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check

  // values read at an edge are those of the cycle before it
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    avs_address_i   <= {idx, 2'b00};
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= {24'h000000, wd};
    // a hung slave is caught by the watchdog
    do begin
      @(posedge ref_clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus

  task wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, d);
  endtask : wr

  task rchk(input logic [7:0] idx, input logic [7:0] want);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    check({8'h00, d}, {8'h00, want});
  endtask : rchk

  task cnt(input logic [15:0] want);
    rchk(`TMB_IDX_CNT_HI, want[15:8]);
    rchk(`TMB_IDX_CNT_LO, want[7:0]);
  endtask : cnt

  task pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge ref_clk_i);
    ev <= 8'h00;
    @(posedge ref_clk_i);
  endtask : pulse

  task run_is(input logic want);
    @(posedge ref_clk_i);
    check({15'h0000, timer_b_running_o}, {15'h0000, want});
  endtask : run_is

  // reference edge detection latency is open, so hold each level a while
  task lfo_rise();
    low_freq_oscillator <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    low_freq_oscillator <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
  endtask : lfo_rise

  task finish_test();
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////
  task t_regs();
    rchk(`TMB_IDX_CTRL_B, 8'h00);
    wr(`TMB_IDX_CTRL_B, 8'hff);
    rchk(`TMB_IDX_CTRL_B, 8'hbb);
    wr(`TMB_IDX_CTRL_C, 8'hff);
    rchk(`TMB_IDX_CTRL_C, 8'hbb);
    wr(`TMB_IDX_CNT_HI, 8'haa);
    rchk(`TMB_IDX_CNT_HI, 8'h00);
    rchk(8'h20, 8'h00);
    wr(`TMB_IDX_RLD_HI, 8'h5a);
    rchk(`TMB_IDX_RLD_HI, 8'h5a);
  endtask : t_regs

  task t_ticks();
    for (int k = 0; k < 4; k++) begin
      wr(`TMB_IDX_CTRL_B, 8'(k));
      wr(`TMB_IDX_RLD_HI, 8'h12);
      wr(`TMB_IDX_RLD_LO, 8'(8'h30 + k));
      pulse(4);
      pulse(k);
      pulse((k + 1) % 4);
      cnt(16'(16'h122f + k));
    end
  endtask : t_ticks

  task t_reload();
    wr(`TMB_IDX_CTRL_B, 8'h00);
    wr(`TMB_IDX_RLD_HI, 8'h00);
    wr(`TMB_IDX_RLD_LO, 8'h50);
    pulse(4);
    wr(`TMB_IDX_RLD_LO, 8'h99);
    cnt(16'h0050);
    pulse(4);
    cnt(16'h0099);
  endtask : t_reload

  task t_underflow();
    wr(`TMB_IDX_IRQ_MASK, 8'h01);
    wr(`TMB_IDX_RLD_LO, 8'h01);
    pulse(4);
    pulse(0);
    cnt(16'h0000);
    pulse(0);
    check({15'h0000, timer_b_underflow_o}, 16'h0001);
    @(posedge ref_clk_i);
    check({15'h0000, timer_b_underflow_o}, 16'h0000);
    check({15'h0000, irq_o}, 16'h0001);
    run_is(1'b0);
    cnt(16'h0000);
    rchk(`TMB_IDX_IRQ_STAT, 8'h01);
    repeat (2) @(posedge ref_clk_i);
    check({15'h0000, irq_o}, 16'h0000);
    wr(`TMB_IDX_CTRL_B, 8'h08);
    pulse(4);
    pulse(0);
    pulse(0);
    run_is(1'b1);
    cnt(16'h0001);
    rchk(`TMB_IDX_IRQ_STAT, 8'h01);
    pulse(5);
  endtask : t_underflow

  task t_modes();
    wr(`TMB_IDX_CTRL_B, 8'h00);
    pulse(6);
    run_is(1'b0);
    wr(`TMB_IDX_CTRL_B, 8'h10);
    pulse(6);
    run_is(1'b1);
    wr(`TMB_IDX_CTRL_B, 8'h80);
    pulse(4);
    pulse(7);
    run_is(1'b0);
    wr(`TMB_IDX_CTRL_B, 8'h00);
    pulse(4);
    pulse(7);
    run_is(1'b1);
    pulse(5);
    for (int m = 2; m < 4; m++) begin
      wr(`TMB_IDX_CTRL_B, {2'b10, 2'(m), 4'h0});
      lfo_rise();
      run_is(1'b1);
      pulse(7);
      run_is(1'b1);
      lfo_rise();
      run_is(1'b0);
      lfo_rise();
      pulse(0);
      pulse(0);
      check({15'h0000, timer_b_underflow_o}, 16'(m - 2));
      run_is(1'b0);
    end
  endtask : t_modes

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_regs();
    t_ticks();
    t_reload();
    t_underflow();
    t_modes();
    finish_test();
  end

  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : tb_timer1_countdown_unit
`default_nettype wire

// ==== tmb_defs.svh ====
`ifndef TMB_DEFS_SVH
`define TMB_DEFS_SVH

// register indices; byte address is four times the index
`define TMB_IDX_CTRL_B    8'h14
`define TMB_IDX_RLD_HI    8'h15
`define TMB_IDX_RLD_LO    8'h16
`define TMB_IDX_CNT_HI    8'h17
`define TMB_IDX_CNT_LO    8'h18
`define TMB_IDX_CTRL_C    8'h19
`define TMB_IDX_IRQ_STAT  8'h1e
`define TMB_IDX_IRQ_MASK  8'h1f

// control register fields, same layout for both control registers
`define TMB_CTL_STOPRX    7
`define TMB_CTL_MODE_HI   5
`define TMB_CTL_MODE_LO   4
`define TMB_CTL_AUTO      3
`define TMB_CTL_TICK_HI   1
`define TMB_CTL_TICK_LO   0
`define TMB_CTL_WR_MASK   8'hbb

// start modes
`define TMB_MODE_MANUAL   2'h0
`define TMB_MODE_TX_END   2'h1
`define TMB_MODE_TRIM     2'h2
`define TMB_MODE_TRIM_UF  2'h3

// tick sources
`define TMB_TICK_13M56    2'h0
`define TMB_TICK_212K     2'h1
`define TMB_TICK_TIMER_A  2'h2
`define TMB_TICK_TIMER_C  2'h3

// interrupt status bits
`define TMB_IRQ_UNDERFLOW 0
`define TMB_IRQ_RX_HALT   1
`define TMB_IRQ_BITS      2

// reset values
`define TMB_RST_BYTE      8'h00
`define TMB_RST_WORD      16'h0000
`define TMB_RST_IRQ       2'h0
`define TMB_RST_DATA      32'h0000_0000

`endif

// ==== tmb_pkg.sv ====
package tmb_pkg;

  // gray along idle -> run -> halted
  typedef enum logic [1:0] {
    TMB_IDLE = 2'h0,
    TMB_RUN  = 2'h1,
    TMB_HALT = 2'h3
  } tmb_state_t;

endpackage : tmb_pkg

// ==== tmb_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmb_defs.svh"

module tmb_timer
  import tmb_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [9:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        tick_13m56_i,
  input  wire logic        tick_212k_i,
  input  wire logic        timer_a_underflow_i,
  input  wire logic        timer_c_underflow_i,
  input  wire logic        start_now_i,
  input  wire logic        stop_now_i,
  input  wire logic        tx_done_i,
  input  wire logic        rx_first_nibble_i,
  input  wire logic        low_freq_oscillator_i,
  output logic             timer_b_underflow_o,
  output logic             timer_b_running_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // registers and state

  tmb_state_t                 state;
  logic [15:0]                count;
  logic [7:0]                 timer_b_control;
  logic [7:0]                 timer_c_control;
  logic [7:0]                 timer_b_reload_high;
  logic [7:0]                 timer_b_reload_low;
  logic [`TMB_IRQ_BITS-1:0]   irq_status;
  logic [`TMB_IRQ_BITS-1:0]   irq_mask;
  logic                       lfo_prev;

  logic                       timer_b_stop_on_receive;
  logic [1:0]                 timer_b_start_mode;
  logic                       timer_b_auto_reload;
  logic [1:0]                 timer_b_tick_select;
  logic [15:0]                timer_b_reload_word;
  logic                       trim_mode;
  logic                       running;
  logic                       tick;
  logic                       lfo_rise;
  logic                       start_evt;
  logic                       stop_evt;
  logic                       rx_halt_evt;
  logic                       at_zero;
  logic                       uf_evt;
  logic [7:0]                 word_idx;
  logic                       aligned;
  logic                       wr_acc;
  logic                       rd_acc;
  logic [`TMB_IRQ_BITS-1:0]   irq_set;
  logic [`TMB_IRQ_BITS-1:0]   irq_clr;
  logic [`TMB_IRQ_BITS-1:0]   next_irq_status;
  logic [7:0]                 rd_byte;

  // control fields
  assign timer_b_stop_on_receive = timer_b_control[`TMB_CTL_STOPRX];
  assign timer_b_start_mode  = timer_b_control[`TMB_CTL_MODE_HI:`TMB_CTL_MODE_LO];
  assign timer_b_auto_reload = timer_b_control[`TMB_CTL_AUTO];
  assign timer_b_tick_select = timer_b_control[`TMB_CTL_TICK_HI:`TMB_CTL_TICK_LO];
  assign timer_b_reload_word = {timer_b_reload_high, timer_b_reload_low};

  assign trim_mode = (timer_b_start_mode == `TMB_MODE_TRIM) ||
                     (timer_b_start_mode == `TMB_MODE_TRIM_UF);
  assign running   = (state == TMB_RUN);
  assign lfo_rise  = low_freq_oscillator_i && !lfo_prev;
  assign at_zero   = (count == `TMB_RST_WORD);

  ////////////////////////////////////////////////////////////////////////
  // tick source

  always_comb begin
    case (timer_b_tick_select)
      `TMB_TICK_13M56:   tick = tick_13m56_i;
      `TMB_TICK_212K:    tick = tick_212k_i;
      `TMB_TICK_TIMER_A: tick = timer_a_underflow_i;
      `TMB_TICK_TIMER_C: tick = timer_c_underflow_i;
      default:           tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // start and stop events

  always_comb begin
    start_evt = start_now_i;
    if (timer_b_start_mode == `TMB_MODE_TX_END && tx_done_i) begin
      start_evt = 1'b1;
    end
    if (trim_mode && lfo_rise && !running) begin
      start_evt = 1'b1;
    end
  end

  // receive stop only outside trimming
  assign rx_halt_evt = running && timer_b_stop_on_receive && !trim_mode && rx_first_nibble_i;

  // stop wins over a start arriving in the same cycle
  assign stop_evt = stop_now_i || rx_halt_evt || (trim_mode && lfo_rise && running);

  // trimming without underflow just parks at zero, no event
  assign uf_evt = running && !stop_evt && !start_evt && tick && at_zero &&
                  (timer_b_start_mode != `TMB_MODE_TRIM);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lfo_prev <= 1'b0;
    end else begin
      lfo_prev <= low_freq_oscillator_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter and state

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= TMB_IDLE;
      count <= `TMB_RST_WORD;
    end else if (stop_evt) begin
      state <= rx_halt_evt ? TMB_HALT : TMB_IDLE;
    end else if (start_evt) begin
      state <= TMB_RUN;
      count <= timer_b_reload_word;
    end else if (running && tick) begin
      if (!at_zero) begin
        count <= count - 16'h0001;
      end else if (timer_b_start_mode == `TMB_MODE_TRIM) begin
        state <= TMB_IDLE;
      end else if (timer_b_auto_reload) begin
        count <= timer_b_reload_word;
      end else begin
        state <= TMB_IDLE;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_b_underflow_o <= 1'b0;
      timer_b_running_o   <= 1'b0;
    end else begin
      timer_b_underflow_o <= uf_evt;
      timer_b_running_o   <= running;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then the answer

  assign word_idx = avs_address_i[9:2];
  assign aligned  = (avs_address_i[1:0] == 2'h0);
  assign wr_acc   = avs_write_i && !avs_waitrequest_o && aligned;
  assign rd_acc   = avs_read_i && !avs_waitrequest_o && aligned;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_b_control     <= `TMB_RST_BYTE;
      timer_c_control     <= `TMB_RST_BYTE;
      timer_b_reload_high <= `TMB_RST_BYTE;
      timer_b_reload_low  <= `TMB_RST_BYTE;
      irq_mask            <= `TMB_RST_IRQ;
    end else if (wr_acc) begin
      case (word_idx)
        `TMB_IDX_CTRL_B:   timer_b_control <= avs_writedata_i[7:0] & `TMB_CTL_WR_MASK;
        `TMB_IDX_CTRL_C:   timer_c_control <= avs_writedata_i[7:0] & `TMB_CTL_WR_MASK;
        `TMB_IDX_RLD_HI:   timer_b_reload_high <= avs_writedata_i[7:0];
        `TMB_IDX_RLD_LO:   timer_b_reload_low  <= avs_writedata_i[7:0];
        `TMB_IDX_IRQ_MASK: irq_mask <= avs_writedata_i[`TMB_IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
  end

  // count bytes are live; reading them during reception is software's hazard
  always_comb begin
    case (word_idx)
      `TMB_IDX_CTRL_B:   rd_byte = timer_b_control;
      `TMB_IDX_CTRL_C:   rd_byte = timer_c_control;
      `TMB_IDX_RLD_HI:   rd_byte = timer_b_reload_high;
      `TMB_IDX_RLD_LO:   rd_byte = timer_b_reload_low;
      `TMB_IDX_CNT_HI:   rd_byte = count[15:8];
      `TMB_IDX_CNT_LO:   rd_byte = count[7:0];
      `TMB_IDX_IRQ_STAT: rd_byte = {6'h00, irq_status};
      `TMB_IDX_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default:           rd_byte = `TMB_RST_BYTE;
    endcase
  end

  // data is captured in the wait cycle so it stands with waitrequest low
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= `TMB_RST_DATA;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= aligned ? {24'h000000, rd_byte} : `TMB_RST_DATA;
    end
  end

  a_bus_one_wait: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request got no answer cycle");

  a_answer_one_cycle: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  a_idle_bus_waits: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !avs_read_i && !avs_write_i |=> avs_waitrequest_o)
    else $error("waitrequest dropped without a request");

  a_ctrl_write_mask: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && word_idx == `TMB_IDX_CTRL_B
    |=> timer_b_control == (8'($past(avs_writedata_i)) & `TMB_CTL_WR_MASK))
    else $error("control write not stored");

  a_reload_low_write: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && word_idx == `TMB_IDX_RLD_LO
    |=> timer_b_reload_low == 8'($past(avs_writedata_i)))
    else $error("reload low write not stored");

  a_unaligned_write_ignored: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    avs_write_i && !aligned |=> $stable(timer_b_control) && $stable(timer_b_reload_high)
    && $stable(timer_b_reload_low))
    else $error("unaligned write changed a register");

  ////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, cleared by reading, a new event beats the clear

  always_comb begin
    irq_set = `TMB_RST_IRQ;
    irq_set[`TMB_IRQ_UNDERFLOW] = uf_evt;
    irq_set[`TMB_IRQ_RX_HALT]   = rx_halt_evt;
    // clear only what the read reported; a bit set during the wait cycle survives
    irq_clr = (rd_acc && word_idx == `TMB_IDX_IRQ_STAT) ?
              avs_readdata_o[`TMB_IRQ_BITS-1:0] : `TMB_RST_IRQ;
    next_irq_status = (irq_status & ~irq_clr) | irq_set;
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_status <= `TMB_RST_IRQ;
      irq_o      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq_o      <= |(next_irq_status & irq_mask);
    end
  end

  a_rx_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rx_halt_evt |=> irq_status[`TMB_IRQ_RX_HALT])
    else $error("receive halt flag missing");

  a_stat_read_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_acc && word_idx == `TMB_IDX_IRQ_STAT && !uf_evt && !rx_halt_evt
    |=> (irq_status & avs_readdata_o[`TMB_IRQ_BITS-1:0]) == `TMB_RST_IRQ)
    else $error("status read did not clear reported bits");

  a_quiet_no_irq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    irq_status == `TMB_RST_IRQ |-> !irq_o)
    else $error("interrupt without a status bit");

  ////////////////////////////////////////////////////////////////////////
  // assertions

  a_start_loads_word: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    start_evt && !stop_evt |=> running && count == $past(timer_b_reload_word))
    else $error("start did not load reload word");

  a_rx_halts_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    running && timer_b_stop_on_receive && !trim_mode && rx_first_nibble_i
    |=> state == TMB_HALT ##1 (state == TMB_HALT || $past(start_evt)))
    else $error("receive did not halt the timer");

  a_trim_ignores_rx: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    running && trim_mode && rx_first_nibble_i && !lfo_rise && !stop_now_i
    |=> state != TMB_HALT)
    else $error("receive stop acted in trimming");

  a_tx_end_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    timer_b_start_mode == `TMB_MODE_TX_END && tx_done_i && !stop_evt |=> running)
    else $error("end of transmission did not start");

  a_manual_no_auto: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    timer_b_start_mode == `TMB_MODE_MANUAL && !running && !start_now_i |=> !running)
    else $error("timer started by itself");

  a_trim_edge_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trim_mode && lfo_rise && running |=> state == TMB_IDLE)
    else $error("reference edge did not stop trimming");

  a_trim_no_uf: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    timer_b_start_mode == `TMB_MODE_TRIM |=> !timer_b_underflow_o)
    else $error("underflow in trimming without underflow");

  a_reload_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    uf_evt && timer_b_auto_reload
    |=> running && count == $past(timer_b_reload_word) && timer_b_underflow_o)
    else $error("auto reload failed at zero");

  a_zero_stop: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    uf_evt && !timer_b_auto_reload |=> state == TMB_IDLE && at_zero)
    else $error("timer kept running after zero");

  a_uf_sets_flag: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    uf_evt |=> irq_status[`TMB_IRQ_UNDERFLOW] ##1 (irq_o || !irq_mask[`TMB_IRQ_UNDERFLOW]
    || !irq_status[`TMB_IRQ_UNDERFLOW]))
    else $error("underflow flag or interrupt missing");

  a_tick_gates_count: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    running && !tick && !start_evt && !stop_evt |=> $stable(count) && running)
    else $error("count moved without a tick");

  a_decrement_one: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    running && tick && !at_zero && !start_evt && !stop_evt
    |=> count == $past(count) - 16'h0001)
    else $error("count did not drop by one");

  a_reload_no_disturb: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && (word_idx == `TMB_IDX_RLD_HI || word_idx == `TMB_IDX_RLD_LO)
    && running && !tick && !start_evt && !stop_evt |=> $stable(count))
    else $error("reload write disturbed the count");

  a_halt_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state == TMB_HALT && !start_evt && !stop_evt |=> state == TMB_HALT && $stable(count))
    else $error("halted timer moved");

  a_stopped_count_still: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !running && !start_evt |=> $stable(count))
    else $error("stopped count changed");

  a_trim_edge_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trim_mode && lfo_rise && !running && !stop_now_i |=> running)
    else $error("reference edge did not start trimming");

  a_trim_zero_park: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    running && tick && at_zero && timer_b_start_mode == `TMB_MODE_TRIM
    && !start_evt && !stop_evt |=> state == TMB_IDLE)
    else $error("trimming without underflow did not park");

  a_running_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    running |=> timer_b_running_o)
    else $error("running output low while running");

  a_stopped_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !running |=> !timer_b_running_o)
    else $error("running output high while stopped");

  a_underflow_out: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    uf_evt |=> timer_b_underflow_o)
    else $error("underflow output missing");

endmodule : tmb_timer

`default_nettype wire
